// file: tb_video_fault_trigger_logic.sv
// self-checking bench for the two-input fault trigger block
`timescale 1ns/100ps
module tb_video_fault_trigger_logic;
	logic                           clk_sys;
	logic                           rst = 1'h1;
	logic                           ce = 1'h1;
	logic                           frame_tick = 1'h0;
	logic                           reg_wr = 1'h0;
	logic                           reg_rd = 1'h0;
	logic                           monitor_sw = 1'h0;
	logic [2:0]                     pins = 3'h0;
	logic [7:0]                     reg_addr = 8'h0;
	logic [31:0]                    reg_wdata = 32'h0;
	logic [vft_pkg::NUM_COND-1:0]   input1_cond = 24'h0;
	logic [vft_pkg::NUM_COND-1:0]   input2_cond = 24'h0;
	logic [31:0]                    reg_rdata;
	logic [vft_pkg::NUM_INPUTS-1:0] fault_out;
	logic                           route_sel, menu_active, irq;
	int                             num_errors = 0;
	int                             checks = 0;

	vft_top uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .frame_tick(frame_tick),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .input1_cond(input1_cond), .input2_cond(input2_cond),
		.monitor_sw(monitor_sw), .push_btn(pins[0]), .toggle_btn(pins[1]), .gpi_in(pins[2]),
		.fault_out(fault_out), .route_sel(route_sel), .menu_active(menu_active), .irq(irq));

	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// look at outputs mid-cycle so edge updates have landed
	task automatic sn(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : sn
	// inputs change only on a rising edge; a mid-cycle check waits for the next one
	task automatic ed;
		if (clk_sys !== 1'h1) @(posedge clk_sys);
	endtask : ed
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ed;
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge clk_sys);
		reg_wr    <= 1'h0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		ed;
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge clk_sys);
		reg_rd   <= 1'h0;
		sn(0);
		chk(reg_rdata, e);
		@(posedge clk_sys);
	endtask : rd
	task automatic tk(input int n);
		ed;
		repeat (n) begin
			frame_tick <= 1'h1;
			@(posedge clk_sys);
			frame_tick <= 1'h0;
			@(posedge clk_sys);
		end
	endtask : tk
	// pins pass a two-stage sync, so each press is held well beyond it
	task automatic pulse(input logic [2:0] p);
		ed;
		pins <= p;
		repeat (6) @(posedge clk_sys);
		pins <= 3'h0;
		sn(6);
	endtask : pulse
	function automatic logic [7:0] ad(input int i, input logic [3:0] o);
		return 8'(vft_pkg::A_IN_BASE + 8'(i) * vft_pkg::A_IN_STEP + {4'h0, o});
	endfunction : ad
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic t_regs;
		for (int i = 0; i < 2; i++) begin
			rd(ad(i, vft_pkg::O_SETUP), 32'h0200_0001);
			rd(ad(i, vft_pkg::O_HOLD), 32'h0000_001e);
		end
		wr(vft_pkg::A_CTRL, 32'hffff_ff7c);
		rd(vft_pkg::A_CTRL, 32'h0000_ff7c);
		wr(vft_pkg::A_CTRL, 32'h0);
		rd(8'h80, 32'h0);
		ce <= 1'h0;
		wr(vft_pkg::A_IRQ_MSK, 32'h3);
		ce <= 1'h1;
		rd(vft_pkg::A_IRQ_MSK, 32'h0);
	endtask : t_regs
	task automatic t_loss;
		wr(vft_pkg::A_IRQ_MSK, 32'h1);
		input1_cond[0] <= 1'h1;
		sn(1);
		chk(fault_out, 2'h1);
		ed;
		input1_cond[0] <= 1'h0;
		sn(2);
		chk(irq, 1'h1);
		wr(vft_pkg::A_IRQ_ST, 32'h1);
		sn(0);
		chk(irq, 1'h0);
		tk(29);
		sn(0);
		chk(fault_out, 2'h1);
		tk(1);
		sn(0);
		chk(fault_out, 2'h0);
		wr(ad(0, vft_pkg::O_HOLD), 32'h0);
		wr(vft_pkg::A_CTRL, 32'h80);
		for (int k = 0; k < 3; k++) begin
			ed;
			input1_cond[0] <= 1'h1;
			repeat (2) @(posedge clk_sys);
			input1_cond[0] <= 1'h0;
			tk(40);
			sn(0);
			chk(fault_out, 2'h1);
			if (k == 0)
				wr(vft_pkg::A_CMD, 32'h1);
			else
				pulse(k == 1 ? 3'h4 : 3'h2);
			sn(0);
			chk(fault_out, 2'h0);
		end
		wr(vft_pkg::A_CTRL, 32'h0);
		wr(ad(0, vft_pkg::O_HOLD), 32'h1e);
	endtask : t_loss
	task automatic t_and;
		wr(vft_pkg::A_IRQ_ST, 32'h3);
		wr(ad(1, vft_pkg::O_SETUP), 32'h0000_0003);
		input2_cond <= 24'h3;
		sn(3);
		chk(fault_out, 2'h0);
		ed;
		input2_cond <= 24'h1;
		wr(ad(1, vft_pkg::O_SETUP), 32'h0300_0003);
		wr(vft_pkg::A_CMD, 32'h1);
		sn(0);
		chk(fault_out, 2'h0);
		ed;
		input2_cond <= 24'h3;
		sn(2);
		chk({irq, fault_out}, 3'h2);
		ed;
		input2_cond <= 24'h0;
		wr(ad(1, vft_pkg::O_SETUP), 32'h0200_0001);
		wr(vft_pkg::A_CMD, 32'h1);
	endtask : t_and
	task automatic t_dur;
		wr(ad(0, vft_pkg::O_SETUP), 32'h0200_0100);
		wr(ad(0, vft_pkg::O_THRA), 32'h0000_0300);
		wr(ad(0, vft_pkg::O_THRB), 32'h0002_0000);
		wr(ad(0, vft_pkg::O_HOLD), 32'h1);
		input1_cond[8] <= 1'h1;
		tk(2);
		sn(0);
		chk(fault_out, 2'h0);
		tk(1);
		sn(2);
		chk(fault_out, 2'h1);
		ed;
		input1_cond[8] <= 1'h0;
		tk(1);
		sn(0);
		chk(fault_out, 2'h1);
		tk(3);
		sn(2);
		chk(fault_out, 2'h0);
		wr(ad(0, vft_pkg::O_SETUP), 32'h0200_0001);
	endtask : t_dur
	task automatic t_menu;
		pulse(3'h1);
		chk(menu_active, 1'h1);
		wr(vft_pkg::A_CMD, 32'h2);
		sn(0);
		chk(menu_active, 1'h0);
		pulse(3'h1);
		ed;
		monitor_sw <= 1'h1;
		sn(8);
		chk(menu_active, 1'h0);
		rd(vft_pkg::A_STAT, 32'h10);
		pulse(3'h1);
		chk({menu_active, route_sel}, 2'h1);
		wr(vft_pkg::A_CTRL, 32'h1);
		input2_cond[0] <= 1'h1;
		sn(3);
		chk(route_sel, 1'h0);
		ed;
		input2_cond[0] <= 1'h0;
		wr(vft_pkg::A_CMD, 32'h1);
	endtask : t_menu

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		t_regs;
		t_loss;
		t_and;
		t_dur;
		t_menu;
		end_of_test;
	end
	// whole run is well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		end_of_test;
	end
endmodule : tb_video_fault_trigger_logic

bind vft_top vft_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.input1_cond(input1_cond), .monitor_sw(monitor_sw), .fault_out(fault_out),
	.route_sel(route_sel), .menu_active(menu_active), .irq(irq));

// file: vft_assertions.sv
// port-level assertions for the video fault trigger block
`timescale 1ns/100ps
module vft_assertions (
	// clock and reset
	input wire logic                           clk_sys,
	input wire logic                           rst,
	// register port
	input wire logic [7:0]                     reg_addr,
	input wire logic [31:0]                    reg_wdata,
	input wire logic                           reg_wr,
	input wire logic                           reg_rd,
	input wire logic [31:0]                    reg_rdata,
	// conditions and pins
	input wire logic [vft_pkg::NUM_COND-1:0]   input1_cond,
	input wire logic                           monitor_sw,
	// outputs
	input wire logic [vft_pkg::NUM_INPUTS-1:0] fault_out,
	input wire logic                           route_sel,
	input wire logic                           menu_active,
	input wire logic                           irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_ctrl_wr;
		reg_wr && reg_addr == vft_pkg::A_CTRL;
	endsequence
	sequence s_ctrl_rd;
		reg_rd && reg_addr == vft_pkg::A_CTRL;
	endsequence
	sequence s_menu_ret;
		reg_wr && reg_addr == vft_pkg::A_CMD && reg_wdata[vft_pkg::CMD_RETURN_BIT];
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	// upper half of the control word is reserved and must read zero
	a_ctrl_readback: assert property (s_ctrl_wr ##2 s_ctrl_rd |=>
		reg_rdata == ($past(reg_wdata, 3) & 32'h0000_ffff)) else $error("control readback wrong");
	a_status_view: assert property (reg_rd && reg_addr == vft_pkg::A_STAT |=>
		reg_rdata[3:0] == {$past(menu_active), $past(route_sel), $past(fault_out)})
		else $error("status word differs from outputs");
	// two cycles of slack cover the qualified lanes' extra register
	a_fault_cause: assert property ($rose(fault_out[0]) |->
		$past(input1_cond) != 24'h0 || $past(input1_cond, 2) != 24'h0)
		else $error("fault 1 raised with no condition");
	a_irq_cause: assert property ($rose(irq) |-> $past(reg_wr) || $past(reg_wr, 2) ||
		$past(fault_out, 2) != $past(fault_out, 3)) else $error("interrupt with no event");
	a_menu_return: assert property (s_menu_ret |-> ##2 !menu_active)
		else $error("menu return command ignored");
	a_monitor_exit: assert property (monitor_sw [*6] |=> !menu_active)
		else $error("setup menu active in monitor mode");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> fault_out == 2'h0 && !irq &&
		!route_sel && !menu_active && reg_rdata == 32'h0) else $error("outputs not cleared by reset");
endmodule : vft_assertions

// file: vft_hold.sv
// fault hold: until clear or for a frame count
`timescale 1ns/100ps
module vft_hold (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       frame_tick,
	// control
	input  wire logic       fault_mode_en,
	input  wire logic       combined,
	input  wire logic [7:0] hold_time,
	input  wire logic       clear,
	// result
	output logic            fault_out
);
	logic       active_d_reg;
	logic       held_reg;
	logic [7:0] timer_reg;
	logic       rise;
	logic       until_clear;

	assign rise        = combined & ~active_d_reg;
	assign until_clear = (hold_time == vft_pkg::HOLD_UNTIL);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			active_d_reg <= 1'b0;
		end else if (ce) begin
			active_d_reg <= combined;
		end
	end

	// a new fault in the clear cycle still sets the hold
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			held_reg  <= 1'b0;
			timer_reg <= '0;
		end else if (ce) begin
			if (rise) begin
				held_reg  <= 1'b1;
				timer_reg <= (hold_time > vft_pkg::HOLD_MAX) ? vft_pkg::HOLD_MAX : hold_time;
			end else if (clear) begin
				held_reg <= 1'b0;
			end else if (frame_tick && held_reg && !until_clear && !combined) begin
				if (timer_reg <= 8'h01) begin
					held_reg <= 1'b0;
				end
				timer_reg <= (timer_reg == 8'h00) ? 8'h00 : timer_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fault_out <= 1'b0;
		end else if (ce) begin
			fault_out <= fault_mode_en & (combined | held_reg);
		end
	end
endmodule : vft_hold

// file: vft_pkg.sv
// constants, register map and field layout for the video fault trigger block
package vft_pkg;
	localparam int NUM_INPUTS    = 2;
	localparam int NUM_COND      = 24;
	localparam int DUR_W         = 8;
	localparam int PER_CLASS     = 4;
	// condition lanes
	localparam int C_LOSS        = 0;
	localparam int C_FREEZE      = 1;
	localparam int C_BLACK       = 2;
	localparam int C_INVALID     = 3;
	localparam int C_GLOSS       = 4;
	localparam int C_OVER        = 8;
	localparam int C_SIL         = 12;
	localparam int C_PHASE       = 16;
	localparam int C_MONO        = 20;
	// register byte addresses
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_CMD     = 8'h04;
	localparam logic [7:0] A_STAT    = 8'h08;
	localparam logic [7:0] A_IRQ_ST  = 8'h0c;
	localparam logic [7:0] A_IRQ_MSK = 8'h10;
	localparam logic [7:0] A_IN_BASE = 8'h20;
	localparam logic [7:0] A_IN_STEP = 8'h10;
	localparam logic [3:0] O_SETUP   = 4'h0;
	localparam logic [3:0] O_HOLD    = 4'h4;
	localparam logic [3:0] O_THRA    = 4'h8;
	localparam logic [3:0] O_THRB    = 4'hc;
	// control register fields
	localparam int SMODE_LSB     = 0;
	localparam int GENLOCK_SOURCE_SELECT_LSB      = 2;
	localparam int MONITOR_ROUTE_SELECT_LSB      = 4;
	localparam int CONTROL_SYSTEM_SELECT_BIT      = 6;
	localparam int GPI_CLR_BIT   = 7;
	localparam int SWITCH_LINE_SELECT_LSB      = 8;
	localparam int CTRL_USED     = 16;
	localparam logic [1:0] SMODE_AUTO = 2'h1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// command bits
	localparam int CMD_CLEAR_BIT  = 0;
	localparam int CMD_RETURN_BIT = 1;
	// setup register
	localparam int COMBINE_AND_BIT = 24;
	localparam int FAULT_MODE_BIT  = 25;
	localparam logic [31:0] SETUP_RESET = 32'h0200_0001;
	// hold register
	localparam logic [7:0] HOLD_RESET  = 8'h1e;
	localparam logic [7:0] HOLD_UNTIL  = 8'h00;
	localparam logic [7:0] HOLD_MAX    = 8'hfe;
	// status bits
	localparam int STAT_ROUTE_BIT = 2;
	localparam int STAT_MENU_BIT  = 3;
	localparam int STAT_MONSW_BIT = 4;
	// release time
	localparam int RELEASE_TIME_MS = 1000;
	localparam int FRAME_RATE_HZ   = 30;
	localparam int REL_CALC        = RELEASE_TIME_MS * FRAME_RATE_HZ / 1000;
	localparam logic [7:0] REL_FRAMES = (REL_CALC < 1) ? 8'h01 : 8'(REL_CALC);
	localparam logic [31:0] THRA_RESET = 32'h0101_0101;
	localparam logic [31:0] THRB_RESET = {8'h00, REL_FRAMES, 16'h0101};
	typedef enum logic {MENU_MONITOR, MENU_SETUP} vft_menu_t;
endpackage : vft_pkg

// file: vft_qualify.sv
// duration qualifier with release delay for one fault condition
`timescale 1ns/100ps
module vft_qualify #(
	parameter int DUR_W = 8
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             frame_tick,
	// condition
	input  wire logic             cond_raw,
	input  wire logic [DUR_W-1:0] dur,
	input  wire logic [DUR_W-1:0] release_frames,
	output logic                  cond_q
);
	if (DUR_W < 1) begin : g_bad_width
		$error("DUR_W must be positive");
	end

	logic [DUR_W-1:0] cnt_reg;
	logic [DUR_W:0]   cnt_inc;
	logic [DUR_W-1:0] limit;

	assign cnt_inc = {1'b0, cnt_reg} + {{DUR_W{1'b0}}, 1'b1};
	assign limit   = cond_q ? release_frames : dur;

	// a zero limit acts as one frame
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cond_q  <= 1'b0;
			cnt_reg <= '0;
		end else if (ce) begin
			if (cond_raw == cond_q) begin
				cnt_reg <= '0;
			end else if (frame_tick) begin
				if (cnt_inc >= {1'b0, limit}) begin
					cond_q  <= cond_raw;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_inc[DUR_W-1:0];
				end
			end
		end
	end
endmodule : vft_qualify

// file: vft_top.sv
// two-input fault trigger logic with settings registers and auto switching
// Functional notes
// - two independent fault outputs, one per input, each with its own settings
// - audio conditions trigger only after staying active their programmed duration
// - trigger releases within a release time, default one second, configurable
// - in auto switch mode the fault outputs steer router input selection
// - fault held until user clear, or 1 to 254 frames, default 30
// - fault shown while condition active and fault mode enabled
// - held fault cleared by clear input, clear menu command, or toggle outside menu
// - enabled conditions combined by OR or AND, OR by default
// - each condition has an enable; only video loss enabled after reset
// - video loss is instant; video invalid has its own duration
// - conditions: video loss/freeze/black/invalid, group loss 1-4, over/silence/phase/mono 1-4 each
// - menu return command leaves setup and goes back to monitoring
// - settings held: switch mode, switch line, genlock, monitor route, control system
// - setup menu only with monitor switch off; otherwise monitoring display
`timescale 1ns/100ps
module vft_top (
	// clock, reset, enable
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	input  wire logic                          ce,
	input  wire logic                          frame_tick,
	// register port
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [31:0]                   reg_rdata,
	// raw detector conditions per input
	input  wire logic [vft_pkg::NUM_COND-1:0]  input1_cond,
	input  wire logic [vft_pkg::NUM_COND-1:0]  input2_cond,
	// card edge pins
	input  wire logic                          monitor_sw,
	input  wire logic                          push_btn,
	input  wire logic                          toggle_btn,
	input  wire logic                          gpi_in,
	// outputs
	output logic      [vft_pkg::NUM_INPUTS-1:0] fault_out,
	output logic                               route_sel,
	output logic                               menu_active,
	output logic                               irq
);
	localparam int NI = vft_pkg::NUM_INPUTS;
	localparam int NC = vft_pkg::NUM_COND;

	// the map serves exactly two inputs and a lane field below the combine bit
	if (NI != 2) begin : g_bad_inputs
		$error("fault trigger logic serves exactly two inputs");
	end
	if (vft_pkg::C_MONO + vft_pkg::PER_CLASS != NC) begin : g_bad_map
		$error("condition lanes do not fill the enable field");
	end
	if (NC > vft_pkg::COMBINE_AND_BIT) begin : g_bad_lanes
		$error("condition lanes overlap the combine bit");
	end
	// a default hold must be a frame count the timer can serve
	if (vft_pkg::HOLD_RESET > vft_pkg::HOLD_MAX) begin : g_bad_hold
		$error("default hold time out of range");
	end

	// register storage
	logic [31:0] ctrl_reg;
	logic [31:0] setup_reg [NI];
	logic [7:0]  hold_reg  [NI];
	logic [31:0] thra_reg  [NI];
	logic [31:0] thrb_reg  [NI];
	logic [NI-1:0] irq_st_reg;
	logic [NI-1:0] irq_msk_reg;
	logic [NC-1:0] cond_raw [NI];
	logic [NC-1:0] cond_q   [NI];
	logic [NI-1:0] combined;
	logic [NI-1:0] fault_hold_out;
	logic [NI-1:0] fault_d_reg;
	logic [NI-1:0] fault_rise;
	logic          clear_pulse;
	logic          cmd_clear;
	logic          cmd_return;
	vft_pkg::vft_menu_t menu_state_reg;

	assign cond_raw[0] = input1_cond;
	assign cond_raw[1] = input2_cond;

	// input block decode: true when the address hits that register of one input
	function automatic logic in_hit(input logic [7:0] a, input int idx, input logic [3:0] off);
		logic [7:0] base;
		base = vft_pkg::A_IN_BASE + 8'(idx) * vft_pkg::A_IN_STEP;
		return a == (base + {4'h0, off});
	endfunction : in_hit

	// write decode shared by the control, command and interrupt registers
	function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] target);
		return wr && (a == target);
	endfunction : wr_hit

	// duration field serving one condition lane
	function automatic logic [7:0] lane_dur(input int lane, input logic [31:0] ta,
			input logic [31:0] tb);
		logic [7:0] d;
		d = 8'h01;
		if (lane == vft_pkg::C_INVALID) d = tb[15:8];
		else if (lane >= vft_pkg::C_MONO) d = tb[7:0];
		else if (lane >= vft_pkg::C_PHASE) d = ta[31:24];
		else if (lane >= vft_pkg::C_SIL) d = ta[23:16];
		else if (lane >= vft_pkg::C_OVER) d = ta[15:8];
		else if (lane >= vft_pkg::C_GLOSS) d = ta[7:0];
		return d;
	endfunction : lane_dur

	// pin synchronisers; the second stage is read, and the third only for edge detection
	logic [3:0] pin_s1_reg;
	logic [3:0] pin_s2_reg;
	logic [3:0] pin_s3_reg;
	logic       mon_sw_s;
	logic       push_rise;
	logic       toggle_rise;
	logic       gpi_rise;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
		end else if (ce) begin
			pin_s1_reg <= {gpi_in, toggle_btn, push_btn, monitor_sw};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign mon_sw_s    = pin_s2_reg[0];
	assign push_rise   = pin_s2_reg[1] & ~pin_s3_reg[1];
	assign toggle_rise = pin_s2_reg[2] & ~pin_s3_reg[2];
	assign gpi_rise    = pin_s2_reg[3] & ~pin_s3_reg[3];

	// command strobes
	assign cmd_clear  = wr_hit(reg_wr, reg_addr, vft_pkg::A_CMD)
		&& reg_wdata[vft_pkg::CMD_CLEAR_BIT];
	assign cmd_return = wr_hit(reg_wr, reg_addr, vft_pkg::A_CMD)
		&& reg_wdata[vft_pkg::CMD_RETURN_BIT];

	// any of the three clear sources
	assign clear_pulse = cmd_clear
		| (gpi_rise & ctrl_reg[vft_pkg::GPI_CLR_BIT])
		| (toggle_rise & (menu_state_reg == vft_pkg::MENU_MONITOR));

	// settings registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_reg <= vft_pkg::CTRL_RESET;
		end else if (ce && wr_hit(reg_wr, reg_addr, vft_pkg::A_CTRL)) begin
			ctrl_reg <= {16'h0000, reg_wdata[vft_pkg::CTRL_USED-1:0]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_msk_reg <= '0;
		end else if (ce && wr_hit(reg_wr, reg_addr, vft_pkg::A_IRQ_MSK)) begin
			irq_msk_reg <= reg_wdata[NI-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NI; gi++) begin : g_in
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					setup_reg[gi] <= vft_pkg::SETUP_RESET;
					hold_reg[gi]  <= vft_pkg::HOLD_RESET;
					thra_reg[gi]  <= vft_pkg::THRA_RESET;
					thrb_reg[gi]  <= vft_pkg::THRB_RESET;
				end else if (ce && reg_wr) begin
					if (in_hit(reg_addr, gi, vft_pkg::O_SETUP))
						setup_reg[gi] <= {6'h00, reg_wdata[vft_pkg::FAULT_MODE_BIT:0]};
					if (in_hit(reg_addr, gi, vft_pkg::O_HOLD))
						hold_reg[gi] <= reg_wdata[7:0];
					if (in_hit(reg_addr, gi, vft_pkg::O_THRA))
						thra_reg[gi] <= reg_wdata;
					if (in_hit(reg_addr, gi, vft_pkg::O_THRB))
						thrb_reg[gi] <= {8'h00, reg_wdata[23:0]};
				end
			end

			// per condition lane qualification
			genvar li;
			for (li = 0; li < NC; li++) begin : g_lane
				if (li < vft_pkg::C_INVALID) begin : g_inst
					// loss is instant; freeze and black come pre-qualified from detectors
					assign cond_q[gi][li] = cond_raw[gi][li];
				end else begin : g_qual
					vft_qualify #(
						.DUR_W(vft_pkg::DUR_W)
					) u_qual (
						.clk_sys        (clk_sys),
						.rst            (rst),
						.ce             (ce),
						.frame_tick     (frame_tick),
						.cond_raw       (cond_raw[gi][li]),
						.dur            (lane_dur(li, thra_reg[gi], thrb_reg[gi])),
						.release_frames (thrb_reg[gi][23:16]),
						.cond_q         (cond_q[gi][li])
					);
				end
			end

			// combine enabled conditions
			logic [NC-1:0] en;
			assign en = setup_reg[gi][NC-1:0];
			assign combined[gi] = setup_reg[gi][vft_pkg::COMBINE_AND_BIT]
				? ((|en) & (&(~en | cond_q[gi])))
				: (|(en & cond_q[gi]));

			vft_hold u_hold (
				.clk_sys       (clk_sys),
				.rst           (rst),
				.ce            (ce),
				.frame_tick    (frame_tick),
				.fault_mode_en (setup_reg[gi][vft_pkg::FAULT_MODE_BIT]),
				.combined      (combined[gi]),
				.hold_time     (hold_reg[gi]),
				.clear         (clear_pulse),
				.fault_out     (fault_hold_out[gi])
			);
		end
	endgenerate

	assign fault_out = fault_hold_out;

	// interrupt status: set beats write-one clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fault_d_reg <= '0;
		end else if (ce) begin
			fault_d_reg <= fault_hold_out;
		end
	end

	assign fault_rise = fault_hold_out & ~fault_d_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_st_reg <= '0;
		end else if (ce) begin
			if (wr_hit(reg_wr, reg_addr, vft_pkg::A_IRQ_ST))
				irq_st_reg <= (irq_st_reg & ~reg_wdata[NI-1:0]) | fault_rise;
			else
				irq_st_reg <= irq_st_reg | fault_rise;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_st_reg & irq_msk_reg);
		end
	end

	// display menu state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			menu_state_reg <= vft_pkg::MENU_MONITOR;
		end else if (ce) begin
			case (menu_state_reg)
				vft_pkg::MENU_MONITOR: begin
					if (!mon_sw_s && push_rise)
						menu_state_reg <= vft_pkg::MENU_SETUP;
				end
				vft_pkg::MENU_SETUP: begin
					if (mon_sw_s)
						menu_state_reg <= vft_pkg::MENU_MONITOR;
					else if (cmd_return)
						menu_state_reg <= vft_pkg::MENU_MONITOR;
				end
				default: menu_state_reg <= vft_pkg::MENU_MONITOR;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			menu_active <= 1'b0;
		end else if (ce) begin
			menu_active <= (menu_state_reg == vft_pkg::MENU_SETUP);
		end
	end

	// router input selection; auto leaves a faulted input only for a clean one
	logic auto_mode;
	assign auto_mode = ctrl_reg[vft_pkg::SMODE_LSB +: 2] == vft_pkg::SMODE_AUTO;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			route_sel <= 1'b0;
		end else if (ce) begin
			if (auto_mode) begin
				if (!route_sel && fault_hold_out[0] && !fault_hold_out[1])
					route_sel <= 1'b1;
				else if (route_sel && fault_hold_out[1] && !fault_hold_out[0])
					route_sel <= 1'b0;
			end else if (mon_sw_s && push_rise) begin
				route_sel <= ~route_sel;
			end
		end
	end

	// status word built apart so the read mux stays a plain decode
	logic [31:0] status_word;
	always_comb begin
		status_word                          = 32'h0000_0000;
		status_word[NI-1:0]                  = fault_hold_out;
		status_word[vft_pkg::STAT_ROUTE_BIT] = route_sel;
		status_word[vft_pkg::STAT_MENU_BIT]  = menu_active;
		status_word[vft_pkg::STAT_MONSW_BIT] = mon_sw_s;
	end

	// read port: data valid the cycle after the strobe
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr)
			vft_pkg::A_CTRL:    rd_mux = ctrl_reg;
			vft_pkg::A_STAT:    rd_mux = status_word;
			vft_pkg::A_IRQ_ST:  rd_mux[NI-1:0] = irq_st_reg;
			vft_pkg::A_IRQ_MSK: rd_mux[NI-1:0] = irq_msk_reg;
			default:            rd_mux = 32'h0000_0000;
		endcase
		for (int i = 0; i < NI; i++) begin
			if (in_hit(reg_addr, i, vft_pkg::O_SETUP)) rd_mux = setup_reg[i];
			if (in_hit(reg_addr, i, vft_pkg::O_HOLD)) rd_mux = {24'h000000, hold_reg[i]};
			if (in_hit(reg_addr, i, vft_pkg::O_THRA)) rd_mux = thra_reg[i];
			if (in_hit(reg_addr, i, vft_pkg::O_THRB)) rd_mux = thrb_reg[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (ce) begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end
endmodule : vft_top
